// ==== hwwd_pkg.sv ====
// Shared constants, timing figures and state encoding of the watchdog block.
package hwwd_pkg;

  // ==========================================================================
  // Clock rates
  // ==========================================================================
  localparam int CLK_HZ  = 32'h0131_2D00;   // 20 MHz system clock.
  localparam int XTAL_HZ = 32'h0000_8000;   // 32768 Hz crystal clock.

  // ==========================================================================
  // Watchdog timing
  // ==========================================================================
  localparam int WDOG_TIMEOUT_MS     = 32'h0000_05DC;  // 1500 ms.
  localparam int WDOG_TERMINAL_TICKS = XTAL_HZ * WDOG_TIMEOUT_MS / 1000;
  localparam int RELEASE_TICKS       = 32'h0000_1004;  // 4100 crystal cycles.

  // Half a crystal period in ns; a least time, so it rounds up.
  localparam int HALF_XTAL_NS     = 32'h0000_3B9B;   // 15259 ns.
  localparam int HALF_XTAL_CYCLES =
    (HALF_XTAL_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // Two crystal periods without an edge mean the crystal stopped or slowed.
  // A longest time, so it rounds down.
  localparam int XTAL_SLOW_NS     = 32'h0000_EE6B;   // 61035 ns.
  localparam int XTAL_SLOW_CYCLES =
    (XTAL_SLOW_NS * (CLK_HZ / 1_000_000)) / 1000;

  // ==========================================================================
  // Emulator command and flag location
  // ==========================================================================
  localparam logic [7:0]  EMU_CMD_WDOG_RESTART = 8'h14;
  localparam logic [15:0] CFG_FLAG_ADDR        = 16'h2002;
  localparam int          CFG_FLAG_BIT         = 32'h0000_0002;
  localparam logic        FLAG_RESET_VALUE     = 1'h0;

  // ==========================================================================
  // Synchroniser bit positions
  // ==========================================================================
  localparam int SYNC_W       = 32'h0000_0005;
  localparam int SYNC_XTAL    = 32'h0000_0000;
  localparam int SYNC_EXT_N   = 32'h0000_0001;
  localparam int SYNC_EMU_N   = 32'h0000_0002;
  localparam int SYNC_PF_OK   = 32'h0000_0003;
  localparam int SYNC_PF_DIS  = 32'h0000_0004;

  // ==========================================================================
  // Reset sequencer states, Gray coded from run through pulse to hold
  // ==========================================================================
  typedef enum logic [1:0] {
    HWWD_RUN        = 2'h0,
    HWWD_OVF_PULSE  = 2'h1,
    HWWD_OVF_HOLD   = 2'h3,
    HWWD_XTAL_FAULT = 2'h2
  } hwwd_state_t;

endpackage : hwwd_pkg

// ==== hwwd_sync.sv ====
// Two-flop synchroniser for a bundle of asynchronous pin levels.
`timescale 1ns/10ps
module hwwd_sync
  import hwwd_pkg::*;
#(
  parameter int          WIDTH      = SYNC_W,
  parameter logic [31:0] RESET_BITS = 32'h0000_0000
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  // ==========================================================================
  // Next values
  // ==========================================================================
  // The first stage feeds only the second stage, never other logic.
  always_comb begin
    if (!rst_n) begin
      next_stage1   = RESET_BITS[WIDTH-1:0];
      next_sync_out = RESET_BITS[WIDTH-1:0];
    end else begin
      next_stage1   = async_in;
      next_sync_out = stage1;
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge clk) begin
    stage1   <= next_stage1;
    sync_out <= next_sync_out;
  end

endmodule : hwwd_sync

// ==== hwwd_ctrl.sv ====
// Hardware watchdog, crystal monitor and system reset gathering.
`timescale 1ns/10ps

// Operation
// - Reset on reset pin, emulator pin, power fault, crystal fault, overflow.
// - Reset pin or power fault halts logic and clears configuration bits.
// - Watchdog counts crystal cycles; firmware refreshes within 1.5 seconds.
// - Overflow resets processor like reset pin low for half crystal period.
// - After overflow, processor restarts at address 00 after 4100 crystal cycles.
// - Overflow sets the battery-backed overflow flag at 0x2002 bit 2.
// - Firmware clears the overflow flag; reset pin also clears it.
// - Stopped or slow crystal sets flag, full reset when crystal resumes.
// - Nothing internal can switch off the watchdog or crystal monitor.
// - Power-fault input at supply disables watchdog and power-fault detection.
// - Writing one to the refresh bit restarts the watchdog count.
// - Count also restarts while wake is zero or on emulator command 0x14.
module hwwd_ctrl
  import hwwd_pkg::*;
#(
  parameter int WDOG_TERMINAL = WDOG_TERMINAL_TICKS,
  parameter int RELEASE_COUNT = RELEASE_TICKS,
  parameter int PULSE_CYCLES  = HALF_XTAL_CYCLES,
  parameter int SLOW_LIMIT    = XTAL_SLOW_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       crystal_clock_32k,
  input  wire logic       ext_reset_pin_low,
  input  wire logic       emu_reset_pin_n,
  input  wire logic       power_fault_sense_input,
  input  wire logic       power_fault_at_supply,
  input  wire logic       wdog_refresh_bit,
  input  wire logic       wake,
  input  wire logic       emu_cmd_valid,
  input  wire logic [7:0] emu_cmd,
  input  wire logic       flag_clear,
  output logic            cpu_reset,
  output logic            digital_halt,
  output logic            config_clear,
  output logic            wdog_overflow_flag,
  output logic            xtal_fault
);

  localparam int WD_W  = $clog2(WDOG_TERMINAL + 1);
  localparam int MON_W = $clog2(SLOW_LIMIT + 1);
  localparam int PH_MAX = (RELEASE_COUNT > PULSE_CYCLES) ?
                          RELEASE_COUNT : PULSE_CYCLES;
  localparam int PH_W  = $clog2(PH_MAX + 1);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // True when a counter has reached the last step before its limit.
  function automatic logic at_last(input logic [31:0] cnt,
                                   input int          limit);
    at_last = (cnt == 32'(limit - 1));
  endfunction : at_last

  // ==========================================================================
  // Pin synchronisation
  // ==========================================================================
  logic [SYNC_W-1:0] pins_async;
  logic [SYNC_W-1:0] pins;

  // Reset pins sync to their idle high level, power ok to high.
  assign pins_async = {power_fault_at_supply, power_fault_sense_input,
                       emu_reset_pin_n, ext_reset_pin_low,
                       crystal_clock_32k};

  hwwd_sync #(
    .WIDTH      (SYNC_W),
    .RESET_BITS (32'h0000_000E)
  ) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (pins_async),
    .sync_out (pins)
  );

  logic xtal_s;
  logic ext_rst_active;
  logic emu_rst_active;
  logic pf_disable;
  logic pf_low;
  logic pin_reset;

  assign xtal_s         = pins[SYNC_XTAL];
  assign ext_rst_active = !pins[SYNC_EXT_N];
  assign emu_rst_active = !pins[SYNC_EMU_N];
  assign pf_disable     = pins[SYNC_PF_DIS];
  // Tying the sense input to supply masks the power-fault compare.
  assign pf_low         = !pins[SYNC_PF_OK] && !pf_disable;
  assign pin_reset      = ext_rst_active || pf_low;

  // ==========================================================================
  // Crystal edge detect and frequency monitor
  // ==========================================================================
  // The monitor runs on the system clock so that a dead crystal is seen;
  // no input can stop it.
  logic             xtal_q;
  logic             next_xtal_q;
  logic [MON_W-1:0] mon_cnt;
  logic [MON_W-1:0] next_mon_cnt;
  logic             xtal_tick;
  logic             xtal_slow;

  assign xtal_tick = xtal_s && !xtal_q;

  always_comb begin
    next_xtal_q  = xtal_s;
    next_mon_cnt = mon_cnt;
    if (!rst_n) begin
      next_xtal_q  = 1'h0;
      next_mon_cnt = '0;
    end else if (xtal_tick) begin
      next_mon_cnt = '0;
    end else if (!at_last(32'(mon_cnt), SLOW_LIMIT + 1)) begin
      next_mon_cnt = mon_cnt + MON_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    xtal_q  <= next_xtal_q;
    mon_cnt <= next_mon_cnt;
  end

  // An edge in the same cycle means the crystal is back, so the fault state
  // is left on the first resumed edge and not one crystal period later.
  assign xtal_slow = (mon_cnt == MON_W'(SLOW_LIMIT))
                  && !xtal_tick;

  // ==========================================================================
  // Watchdog counter
  // ==========================================================================
  hwwd_state_t     state;
  hwwd_state_t     next_state;
  logic [WD_W-1:0] wd_cnt;
  logic [WD_W-1:0] next_wd_cnt;
  logic            restart;
  logic            wd_overflow;

  // Refresh strobe, sleep state and emulator command all restart the count.
  assign restart = wdog_refresh_bit
                || !wake
                || (emu_cmd_valid && emu_cmd == EMU_CMD_WDOG_RESTART);

  // Overflow on the tick that would reach the 1.5 s terminal count.
  assign wd_overflow = (state == HWWD_RUN) && !pf_disable && !restart
                    && !pin_reset && xtal_tick
                    && at_last(32'(wd_cnt), WDOG_TERMINAL);

  always_comb begin
    next_wd_cnt = wd_cnt;
    if (!rst_n) begin
      next_wd_cnt = '0;
    end else if (restart || pf_disable || pin_reset
                 || state != HWWD_RUN || wd_overflow) begin
      next_wd_cnt = '0;
    end else if (xtal_tick) begin
      next_wd_cnt = wd_cnt + WD_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    wd_cnt <= next_wd_cnt;
  end

  // ==========================================================================
  // Reset sequencer
  // ==========================================================================
  // The pulse phase counts system clocks; the hold phase counts crystal
  // edges, so the release stays tied to the crystal whatever the bus clock.
  logic [PH_W-1:0] ph_cnt;
  logic [PH_W-1:0] next_ph_cnt;

  always_comb begin
    next_state  = state;
    next_ph_cnt = ph_cnt;
    if (!rst_n) begin
      next_state  = HWWD_RUN;
      next_ph_cnt = '0;
    end else if (xtal_slow) begin
      next_state  = HWWD_XTAL_FAULT;
      next_ph_cnt = '0;
    end else if (pin_reset) begin
      next_state  = HWWD_RUN;
      next_ph_cnt = '0;
    end else begin
      case (state)
        HWWD_RUN: begin
          if (wd_overflow) begin
            next_state  = HWWD_OVF_PULSE;
            next_ph_cnt = '0;
          end
        end
        HWWD_OVF_PULSE: begin
          if (at_last(32'(ph_cnt), PULSE_CYCLES)) begin
            next_state  = HWWD_OVF_HOLD;
            next_ph_cnt = '0;
          end else begin
            next_ph_cnt = ph_cnt + PH_W'(1);
          end
        end
        HWWD_OVF_HOLD: begin
          if (xtal_tick) begin
            if (at_last(32'(ph_cnt), RELEASE_COUNT)) begin
              next_state  = HWWD_RUN;
              next_ph_cnt = '0;
            end else begin
              next_ph_cnt = ph_cnt + PH_W'(1);
            end
          end
        end
        HWWD_XTAL_FAULT: begin
          if (xtal_tick) begin
            next_state  = HWWD_OVF_PULSE;
            next_ph_cnt = '0;
          end
        end
        default: begin
          next_state  = HWWD_RUN;
          next_ph_cnt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    state  <= next_state;
    ph_cnt <= next_ph_cnt;
  end

  // ==========================================================================
  // Overflow flag and reset outputs
  // ==========================================================================
  // A set in the same cycle as a clear wins, so no overflow is lost.
  logic flag_set;
  logic flag_clr;
  logic next_flag;
  logic next_cpu_reset;
  logic next_halt;
  logic next_cfg_clear;
  logic next_xtal_fault;

  assign flag_set = wd_overflow
                 || (xtal_slow && state != HWWD_XTAL_FAULT);
  assign flag_clr = flag_clear || ext_rst_active;

  always_comb begin
    if (!rst_n) begin
      next_flag       = FLAG_RESET_VALUE;
      next_cpu_reset  = 1'h1;
      next_halt       = 1'h0;
      next_cfg_clear  = 1'h0;
      next_xtal_fault = 1'h0;
    end else begin
      next_flag       = flag_set || (wdog_overflow_flag && !flag_clr);
      next_cpu_reset  = pin_reset || emu_rst_active
                     || next_state != HWWD_RUN;
      next_halt       = pin_reset;
      next_cfg_clear  = pin_reset
                     || next_state == HWWD_OVF_PULSE;
      next_xtal_fault = next_state == HWWD_XTAL_FAULT;
    end
  end

  always_ff @(posedge clk) begin
    wdog_overflow_flag <= next_flag;
    cpu_reset          <= next_cpu_reset;
    digital_halt       <= next_halt;
    config_clear       <= next_cfg_clear;
    xtal_fault         <= next_xtal_fault;
  end

endmodule : hwwd_ctrl

// ==== hwwd_xtal_model.sv ====
// Crystal partner model that can stop and restart on command.
`timescale 1ns/10ps
module hwwd_xtal_model #(
  parameter int HALF_NS = 510
) (
  input  wire logic run,
  output logic      xtal
);
  // A stopped crystal stands still low, as a dead oscillator would.
  initial xtal = 1'h0;
  always begin
    #(HALF_NS);
    xtal = run ? ~xtal : 1'h0;
  end
endmodule : hwwd_xtal_model

// ==== hwwd_ctrl_checker.sv ====
// Concurrent checks on the watchdog and reset gathering ports.
`timescale 1ns/10ps
module hwwd_ctrl_checker #(
  parameter int PULSE_CYCLES = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wake,
  input wire logic flag_clear,
  input wire logic cpu_reset,
  input wire logic digital_halt,
  input wire logic config_clear,
  input wire logic wdog_overflow_flag,
  input wire logic xtal_fault
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  int cc;
  int next_cc;
  // The pulse length is counted, since a repetition cannot take a parameter.
  always_comb next_cc = config_clear ? cc + 1 : 0;
  always_ff @(posedge clk) cc <= rst_n ? next_cc : 0;
  sequence s_pulse_start;
    config_clear && cpu_reset && !digital_halt;
  endsequence
  a_halt_forces_reset: assert property (digital_halt |-> cpu_reset && config_clear)
    else $error("halt without reset");
  a_clear_needs_reset: assert property (config_clear |-> cpu_reset)
    else $error("clear without reset");
  a_pulse_sets_flag: assert property ($rose(config_clear) && !digital_halt |-> wdog_overflow_flag)
    else $error("pulse without flag");
  a_pulse_length: assert property ($fell(config_clear) && !$past(digital_halt) |-> cc == PULSE_CYCLES)
    else $error("pulse length");
  a_xtal_fault_sets: assert property ($rose(xtal_fault) |-> cpu_reset && wdog_overflow_flag)
    else $error("fault without reset");
  a_xtal_fault_quiet: assert property (xtal_fault && !digital_halt |-> !config_clear)
    else $error("clear during fault");
  a_fault_exit_pulse: assert property ($fell(xtal_fault) |-> s_pulse_start)
    else $error("no reset on resume");
  a_flag_clear_works: assert property (flag_clear && !cpu_reset |=> !wdog_overflow_flag || $rose(cpu_reset))
    else $error("flag not cleared");
  a_flag_sticky: assert property ($fell(wdog_overflow_flag) |-> $past(flag_clear) || digital_halt)
    else $error("flag lost");
  a_wake_holds_count: assert property (!wake && !$past(wake) |-> !$rose(config_clear) || digital_halt)
    else $error("overflow while asleep");
endmodule : hwwd_ctrl_checker

bind hwwd_ctrl hwwd_ctrl_checker #(.PULSE_CYCLES(PULSE_CYCLES)) u_hwwd_ctrl_checker (
  .clk(clk), .rst_n(rst_n), .wake(wake), .flag_clear(flag_clear),
  .cpu_reset(cpu_reset), .digital_halt(digital_halt),
  .config_clear(config_clear), .wdog_overflow_flag(wdog_overflow_flag),
  .xtal_fault(xtal_fault));

// ==== hwwd_ctrl_test.sv ====
// Self-checking testbench of the watchdog and reset gathering block.
`timescale 1ns/10ps
module hw_watchdog_reset_control_test;
  import hwwd_pkg::*;
  // Short counts keep the run brief; the crystal is sped up to match.
  localparam int TERM = 8, REL = 4, PUL = 3, SLOW = 50;
  logic clk = 1'h0, rst_n = 1'h0, xt, xrun = 1'h1, ext_reset_pin_low = 1'h1;
  logic emu_reset_pin_n = 1'h1, power_fault_sense_input = 1'h1;
  logic power_fault_at_supply = 1'h0, wdog_refresh_bit = 1'h0, wake = 1'h1;
  logic emu_cmd_valid = 1'h0, flag_clear = 1'h0;
  logic [7:0] emu_cmd = 8'h00, lfsr = 8'h0A;
  logic cpu_reset, digital_halt, config_clear, wdog_overflow_flag, xtal_fault;
  int errors = 0, cmp_count = 0, mdl = 0, n;
  always #25 clk = ~clk;
  always @(posedge xt) mdl++;
  hwwd_xtal_model u_hwwd_xtal_model (.run(xrun), .xtal(xt));
  hwwd_ctrl #(.WDOG_TERMINAL(TERM), .RELEASE_COUNT(REL), .PULSE_CYCLES(PUL),
    .SLOW_LIMIT(SLOW)) u_hwwd_ctrl (
    .clk(clk), .rst_n(rst_n), .crystal_clock_32k(xt),
    .ext_reset_pin_low(ext_reset_pin_low), .emu_reset_pin_n(emu_reset_pin_n),
    .power_fault_sense_input(power_fault_sense_input),
    .power_fault_at_supply(power_fault_at_supply),
    .wdog_refresh_bit(wdog_refresh_bit), .wake(wake),
    .emu_cmd_valid(emu_cmd_valid), .emu_cmd(emu_cmd), .flag_clear(flag_clear),
    .cpu_reset(cpu_reset), .digital_halt(digital_halt),
    .config_clear(config_clear), .wdog_overflow_flag(wdog_overflow_flag),
    .xtal_fault(xtal_fault));
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc
  // Waits a bounded time for cpu_reset, config_clear or xtal_fault.
  task automatic wait_for(input int sel, input logic v, output int c);
    c = 0;
    while ((sel == 0 ? cpu_reset : sel == 1 ? config_clear : xtal_fault) !== v && c < 3000) begin
      cyc(1);
      c++;
    end
    if (c >= 3000) errors++;
  endtask : wait_for
  task automatic kick(input int k);
    @(posedge clk);
    wdog_refresh_bit <= (k == 0);
    emu_cmd_valid <= (k == 1);
    emu_cmd <= EMU_CMD_WDOG_RESTART;
    wake <= (k != 2);
    repeat (k == 2 ? 2 : 1) @(posedge clk);
    wdog_refresh_bit <= 1'h0;
    emu_cmd_valid <= 1'h0;
    wake <= 1'h1;
    mdl = 0;
  endtask : kick
  task automatic ovf_run(input int k);
    @(posedge xt);
    cyc(4);
    kick(k);
    repeat (2) @(posedge xt);
    lfsr = lfsr_next(lfsr);
    @(posedge clk);
    emu_cmd <= (lfsr == 8'h14) ? 8'h15 : lfsr;
    emu_cmd_valid <= 1'h1;
    @(posedge clk);
    emu_cmd_valid <= 1'h0;
    wait_for(0, 1'h1, n);
    check("ovf_ticks", mdl, TERM);
    check("ovf_flags", {wdog_overflow_flag, config_clear, digital_halt}, 3'h6);
    wait_for(1, 1'h0, n);
    check("pulse", n, PUL);
    mdl = 0;
    wait_for(0, 1'h0, n);
    check("release", mdl, REL);
  endtask : ovf_run
  task automatic pin_case(input logic [2:0] pins, input logic [3:0] exp);
    kick(0);
    {ext_reset_pin_low, emu_reset_pin_n, power_fault_sense_input} <= pins;
    cyc(4);
    check("pins", {cpu_reset, digital_halt, config_clear, xtal_fault}, exp);
    @(posedge clk);
    {ext_reset_pin_low, emu_reset_pin_n, power_fault_sense_input} <= 3'h7;
    power_fault_at_supply <= 1'h0;
    kick(0);
    cyc(4);
    check("pins_off", cpu_reset, 0);
  endtask : pin_case
  task automatic print_verdict;
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  initial begin
    #2000000;
    errors++;
    print_verdict;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    cyc(4);
    check("after_reset", {cpu_reset, wdog_overflow_flag}, 2'h0);
    for (int k = 0; k < 3; k++) begin
      repeat (4) begin
        lfsr = lfsr_next(lfsr);
        repeat (1 + lfsr % (TERM - 2)) @(posedge xt);
        kick(k);
      end
      check("kept_alive", cpu_reset, 0);
      ovf_run(k);
      @(posedge clk);
      flag_clear <= 1'h1;
      @(posedge clk);
      flag_clear <= 1'h0;
      cyc(2);
      check("flag_cleared", wdog_overflow_flag, 0);
    end
    pin_case(3'h6, 4'hE);
    pin_case(3'h5, 4'h8);
    power_fault_at_supply <= 1'h1;
    pin_case(3'h6, 4'h0);
    kick(0);
    power_fault_at_supply <= 1'h1;
    repeat (TERM + 2) @(posedge xt);
    cyc(4);
    check("wd_disabled", cpu_reset, 0);
    power_fault_at_supply <= 1'h0;
    kick(0);
    xrun <= 1'h0;
    wait_for(2, 1'h1, n);
    check("xtal_stop", {cpu_reset, wdog_overflow_flag}, 2'h3);
    xrun <= 1'h1;
    wait_for(1, 1'h1, n);
    check("xtal_resume", xtal_fault, 0);
    wait_for(0, 1'h0, n);
    pin_case(3'h3, 4'hE);
    check("pin_clears_flag", wdog_overflow_flag, 0);
    print_verdict;
  end
endmodule : hw_watchdog_reset_control_test
